// ### cgu_top.v
// Design decisions made here: the APB slave port and the register offsets.
`include "cgu_defines.vh"

module cgu_top (
   // Clock and reset
   input wire i_clk_sys,
   input wire i_nrst,
   // Oscillator input pin, mode straps and wake request
   input wire i_osc,
   input wire [1:0] i_mode_strap,
   input wire i_wake,
   // APB slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] i_pwdata,
   output wire [31:0] o_prdata,
   output wire o_pready,
   output wire o_pslverr,
   // Clock outputs
   output wire o_clk_cpu,
   output wire o_clk_sys,
   output wire [`CGU_NMOD-1:0] o_mod_en,
   output wire o_locked
);

   localparam integer LOCK_INT = `CGU_LOCK_CYC;
   localparam [`CGU_LOCK_W-1:0] LOCK_CYC = LOCK_INT[`CGU_LOCK_W-1:0];

   function is_sel;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         is_sel = (addr == ofs);
      end
   endfunction

   // Bus state
   reg pready_reg, pslverr_reg, hit;
   reg [31:0] prdata_reg, prdata_next;
   wire acc, wr;

   // Software settings
   reg [1:0] mode_sw_reg;
   reg [15:0] fact_sw_reg;
   reg apply_reg, sleep_reg, pdown_reg, strap_done_reg;
   reg [`CGU_NMOD-1:0] moden_reg, slkeep_reg;

   // Active settings
   reg [1:0] mode_act_reg, st_reg, st_next;
   reg [15:0] fact_act_reg;
   reg [`CGU_LOCK_W-1:0] lock_cnt_reg;
   reg locked_reg, div_clr;

   // Clock path
   reg osc_reg, src_tick, phase_reg, free_reg;
   reg [7:0] burst_reg;
   reg [3:0] base_cnt_reg;
   reg clk_cpu_reg, clk_sys_reg;
   reg [`CGU_NMOD-1:0] mod_en_reg;
   wire osc_edge, ref_tick, out_tick, base_tick, free_clk;
   wire gate_sw, gate_cpu, gate_sys, cpu_next, sys_next;

   assign acc = i_psel & i_penable & pready_reg;
   assign wr = acc & i_pwrite;

   always @* begin
      hit = is_sel(i_paddr, `CGU_OFS_CTRL) | is_sel(i_paddr, `CGU_OFS_FACT)
         | is_sel(i_paddr, `CGU_OFS_STAT) | is_sel(i_paddr, `CGU_OFS_MODEN)
         | is_sel(i_paddr, `CGU_OFS_SLKEEP);
      prdata_next = 32'h00000000;
      if (is_sel(i_paddr, `CGU_OFS_CTRL)) begin
         prdata_next[`CGU_CTRL_MODE] = mode_sw_reg;
         prdata_next[`CGU_CTRL_SLEEP] = sleep_reg;
         prdata_next[`CGU_CTRL_PDOWN] = pdown_reg;
      end
      if (is_sel(i_paddr, `CGU_OFS_FACT)) begin
         prdata_next[15:0] = fact_sw_reg;
      end
      if (is_sel(i_paddr, `CGU_OFS_STAT)) begin
         prdata_next[`CGU_STAT_MODE] = mode_act_reg;
         prdata_next[`CGU_STAT_BUSY] = (st_reg != `CGU_ST_RUN) | apply_reg;
         prdata_next[`CGU_STAT_LOCK] = locked_reg;
         prdata_next[`CGU_STAT_SLEEP] = sleep_reg;
         prdata_next[`CGU_STAT_PDOWN] = pdown_reg;
      end
      if (is_sel(i_paddr, `CGU_OFS_MODEN)) begin
         prdata_next[`CGU_NMOD-1:0] = moden_reg;
      end
      if (is_sel(i_paddr, `CGU_OFS_SLKEEP)) begin
         prdata_next[`CGU_NMOD-1:0] = slkeep_reg;
      end
   end

   // Zero-wait APB answer in the first access cycle
   always @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else begin
         pready_reg <= i_psel & ~i_penable;
         pslverr_reg <= i_psel & ~i_penable & ~hit;
         if (i_psel & ~i_penable & ~i_pwrite) begin
            prdata_reg <= prdata_next;
         end
      end
   end

   // Software registers; mode defaults to straps caught after reset
   always @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         mode_sw_reg <= `CGU_MODE_DIRECT;
         fact_sw_reg <= `CGU_FACT_RST;
         apply_reg <= 1'b0;
         sleep_reg <= 1'b0;
         pdown_reg <= 1'b0;
         moden_reg <= `CGU_MODEN_RST;
         slkeep_reg <= `CGU_SLKEEP_RST;
         strap_done_reg <= 1'b0;
      end else begin
         strap_done_reg <= 1'b1;
         if (!strap_done_reg) begin
            mode_sw_reg <= i_mode_strap;
            apply_reg <= 1'b1;
         end else if (wr && is_sel(i_paddr, `CGU_OFS_CTRL)) begin
            mode_sw_reg <= i_pwdata[`CGU_CTRL_MODE];
            apply_reg <= i_pwdata[`CGU_CTRL_APPLY]
               | (apply_reg & (st_reg != `CGU_ST_LOAD));
         end else if (st_reg == `CGU_ST_LOAD) begin
            apply_reg <= 1'b0;
         end
         // sleep request, wake clears unless set again
         if (wr && is_sel(i_paddr, `CGU_OFS_CTRL)) begin
            sleep_reg <= i_pwdata[`CGU_CTRL_SLEEP];
            pdown_reg <= i_pwdata[`CGU_CTRL_PDOWN];
         end else if (i_wake) begin
            sleep_reg <= 1'b0;
         end
         if (wr && is_sel(i_paddr, `CGU_OFS_FACT)) begin
            fact_sw_reg <= i_pwdata[15:0];
         end
         if (wr && is_sel(i_paddr, `CGU_OFS_MODEN)) begin
            moden_reg <= i_pwdata[`CGU_NMOD-1:0];
         end
         if (wr && is_sel(i_paddr, `CGU_OFS_SLKEEP)) begin
            slkeep_reg <= i_pwdata[`CGU_NMOD-1:0];
         end
      end
   end

   // Switch sequencer
   always @* begin
      st_next = st_reg;
      div_clr = 1'b0;
      case (st_reg)
         `CGU_ST_RUN: begin
            if (apply_reg) begin
               st_next = `CGU_ST_STOP;
            end
         end
         `CGU_ST_STOP: begin
            // wait until both clocks rest low
            if (!clk_cpu_reg && !clk_sys_reg) begin
               st_next = `CGU_ST_LOAD;
            end
         end
         `CGU_ST_LOAD: begin
            div_clr = 1'b1;
            st_next = `CGU_ST_LOCK;
         end
         `CGU_ST_LOCK: begin
            if (lock_cnt_reg == {`CGU_LOCK_W{1'b0}}) begin
               st_next = `CGU_ST_RUN;
            end
         end
         default: begin
            st_next = `CGU_ST_RUN;
         end
      endcase
   end

   always @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         st_reg <= `CGU_ST_RUN;
         mode_act_reg <= `CGU_MODE_DIRECT;
         fact_act_reg <= `CGU_FACT_RST;
         lock_cnt_reg <= {`CGU_LOCK_W{1'b0}};
         locked_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         if (st_reg == `CGU_ST_LOAD) begin
            mode_act_reg <= mode_sw_reg;
            fact_act_reg <= fact_sw_reg;
            locked_reg <= 1'b0;
            if (mode_sw_reg == `CGU_MODE_PLL ||
                mode_sw_reg == `CGU_MODE_BASE) begin
               lock_cnt_reg <= LOCK_CYC;
            end else begin
               lock_cnt_reg <= {`CGU_LOCK_W{1'b0}};
            end
         end else if (lock_cnt_reg != {`CGU_LOCK_W{1'b0}}) begin
            lock_cnt_reg <= lock_cnt_reg - {{(`CGU_LOCK_W-1){1'b0}}, 1'b1};
         end else if (st_reg == `CGU_ST_LOCK) begin
            locked_reg <= 1'b1;
         end
      end
   end

   // Oscillator edges and free base oscillator
   assign osc_edge = i_osc ^ osc_reg;
   assign base_tick = (base_cnt_reg == `CGU_BASE_DIV - 4'h1);

   always @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         osc_reg <= 1'b0;
         base_cnt_reg <= 4'h0;
         burst_reg <= 8'h00;
      end else begin
         osc_reg <= i_osc;
         base_cnt_reg <= base_tick ? 4'h0 : base_cnt_reg + 4'h1;
         // each reference event releases N oscillator ticks
         if (div_clr || mode_act_reg != `CGU_MODE_PLL) begin
            burst_reg <= 8'h00;
         end else if (ref_tick) begin
            burst_reg <= {1'b0, fact_act_reg[`CGU_FACT_N]} + 8'h01;
         end else if (burst_reg != 8'h00) begin
            burst_reg <= burst_reg - 8'h01;
         end
      end
   end

   // Predivider on both oscillator edges
   cgu_div #(.W(4)) u_pdiv (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_clr(div_clr),
      .i_en(osc_edge),
      .i_div(fact_act_reg[`CGU_FACT_P]),
      .o_tick(ref_tick)
   );

   always @* begin
      case (mode_act_reg)
         `CGU_MODE_PRESC: src_tick = ref_tick;
         `CGU_MODE_PLL: src_tick = (burst_reg != 8'h00);
         `CGU_MODE_BASE: src_tick = base_tick;
         default: src_tick = 1'b0;
      endcase
   end

   // Output divider
   cgu_div #(.W(4)) u_kdiv (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_clr(div_clr),
      .i_en(src_tick),
      .i_div(fact_act_reg[`CGU_FACT_K]),
      .o_tick(out_tick)
   );

   assign free_clk = (mode_act_reg == `CGU_MODE_DIRECT) ? osc_reg
      : phase_reg;

   // gating only holds a low clock low, never cuts a high phase
   assign gate_sw = (st_reg == `CGU_ST_STOP) | (st_reg == `CGU_ST_LOAD)
      | (st_reg == `CGU_ST_LOCK);
   // sleep stops the CPU clock, power-down stops both
   assign gate_cpu = gate_sw | sleep_reg | pdown_reg;
   assign gate_sys = gate_sw | pdown_reg;
   // A stopped clock restarts only on a rising edge of its source
   assign cpu_next = clk_cpu_reg ? free_clk
      : (~gate_cpu & free_clk & ~free_reg);
   assign sys_next = clk_sys_reg ? free_clk
      : (~gate_sys & free_clk & ~free_reg);

   always @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         clk_cpu_reg <= 1'b0;
         clk_sys_reg <= 1'b0;
         phase_reg <= 1'b0;
         free_reg <= 1'b0;
      end else begin
         clk_cpu_reg <= cpu_next;
         // system clock from the same source as CPU clock
         clk_sys_reg <= sys_next;
         // Divided phase runs even while gated, restarts low on load
         phase_reg <= div_clr ? 1'b0 : (phase_reg ^ out_tick);
         free_reg <= free_clk;
      end
   end

   // Per-module enables change only while the system clock is low
   genvar g;
   generate
      for (g = 0; g < `CGU_NMOD; g = g + 1) begin : g_mod
         always @(posedge i_clk_sys or negedge i_nrst) begin
            if (!i_nrst) begin
               mod_en_reg[g] <= 1'b0;
            end else if (!sys_next) begin
               mod_en_reg[g] <= moden_reg[g] & ~pdown_reg
                  & (~sleep_reg | slkeep_reg[g]);
            end
         end
      end
   endgenerate

   assign o_prdata = prdata_reg;
   assign o_pready = pready_reg;
   assign o_pslverr = pslverr_reg;
   assign o_clk_cpu = clk_cpu_reg;
   assign o_clk_sys = clk_sys_reg;
   assign o_mod_en = mod_en_reg;
   assign o_locked = locked_reg;

endmodule

// ### cgu_defines.vh
`ifndef CGU_DEFINES_VH
`define CGU_DEFINES_VH

// System clock rate and lock wait
`define CGU_CLK_MHZ 25
`define CGU_LOCK_NS 100000
`define CGU_LOCK_CYC ((`CGU_LOCK_NS * `CGU_CLK_MHZ + 999) / 1000)
`define CGU_LOCK_W 12
`define CGU_BASE_DIV 4'h4

// Clock modes
`define CGU_MODE_DIRECT 2'h0
`define CGU_MODE_PRESC 2'h1
`define CGU_MODE_PLL 2'h2
`define CGU_MODE_BASE 2'h3

// Register byte offsets
`define CGU_OFS_CTRL 8'h00
`define CGU_OFS_FACT 8'h04
`define CGU_OFS_STAT 8'h08
`define CGU_OFS_MODEN 8'h0C
`define CGU_OFS_SLKEEP 8'h10

// Control fields
`define CGU_CTRL_MODE 1:0
`define CGU_CTRL_APPLY 2
`define CGU_CTRL_SLEEP 3
`define CGU_CTRL_PDOWN 4

// Factor fields, each holding factor minus one
`define CGU_FACT_P 3:0
`define CGU_FACT_N 10:4
`define CGU_FACT_K 15:12
`define CGU_FACT_RST 16'h0000

// Status fields
`define CGU_STAT_MODE 1:0
`define CGU_STAT_BUSY 2
`define CGU_STAT_LOCK 3
`define CGU_STAT_SLEEP 4
`define CGU_STAT_PDOWN 5

`define CGU_NMOD 8
`define CGU_MODEN_RST 8'hFF
`define CGU_SLKEEP_RST 8'h00

// Switch sequencer states
`define CGU_ST_RUN 2'h0
`define CGU_ST_STOP 2'h1
`define CGU_ST_LOAD 2'h2
`define CGU_ST_LOCK 2'h3

`endif

// ### cgu_div.v
module cgu_div #(
   parameter W = 4
) (
   // Clock and reset
   input wire i_clk_sys,
   input wire i_nrst,
   // Control
   input wire i_clr,
   input wire i_en,
   input wire [W-1:0] i_div,
   // Output event
   output wire o_tick
);

   reg [W-1:0] cnt_reg;
   wire wrap;

   assign wrap = (cnt_reg >= i_div);
   assign o_tick = i_en & wrap;

   // Counts enable events, one tick per div plus one events
   always @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_reg <= {W{1'b0}};
      end else if (i_clr) begin
         cnt_reg <= {W{1'b0}};
      end else if (i_en) begin
         cnt_reg <= wrap ? {W{1'b0}} : cnt_reg + {{(W-1){1'b0}}, 1'b1};
      end
   end

endmodule

// ### cgu_props.sv
`include "cgu_defines.vh"
module cgu_props (
   // Clock and reset
   input logic i_clk_sys,
   input logic i_nrst,
   // APB
   input logic i_psel,
   input logic i_penable,
   input logic i_pwrite,
   input logic [7:0] i_paddr,
   input logic [31:0] i_pwdata,
   input logic [31:0] o_prdata,
   input logic o_pready,
   input logic o_pslverr,
   // Clock outputs
   input logic o_clk_cpu,
   input logic o_clk_sys,
   input logic [`CGU_NMOD-1:0] o_mod_en
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_nrst);
   logic ctl_wr;
   logic map_hit;
   assign ctl_wr = i_psel && i_penable && o_pready && i_pwrite
      && i_paddr == 8'h00;
   assign map_hit = i_paddr[1:0] == 2'h0 && i_paddr <= 8'h10;

   pready_next_a:
   assert property (i_psel && !i_penable |=> o_pready)
      else $error("no ready after setup");
   ready_access_a:
   assert property (o_pready |-> i_psel && i_penable)
      else $error("ready outside access");
   err_map_a:
   assert property (o_pready |-> o_pslverr == !map_hit)
      else $error("error flag does not match map");
   err_data_a:
   assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
      else $error("refused read data not zero");
   clk_pair_a:
   assert property (o_clk_cpu |-> o_clk_sys)
      else $error("cpu clock high while system low");
   apply_stop_a:
   assert property (ctl_wr && i_pwdata[2]
      |-> ##[1:200] !o_clk_cpu && !o_clk_sys)
      else $error("clocks not stopped for switch");
   pdown_gate_a:
   assert property (ctl_wr && i_pwdata[4]
      |-> ##[1:200] o_mod_en == 0 && !o_clk_cpu && !o_clk_sys)
      else $error("power-down did not gate clocks");
   sleep_hold_a:
   assert property (ctl_wr && i_pwdata[3] && !i_pwdata[4]
      |-> ##[1:200] !o_clk_cpu [*8])
      else $error("cpu clock runs in sleep");
endmodule

// ### cgu_osc_model.sv
module cgu_osc_model #(
   parameter int HALF_CYC = 4
) (
   // System clock, only times the level changes
   input logic i_clk,
   // Oscillator pin
   output logic o_osc
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   initial o_osc = 1'b0;
   // Steady source, level changes just after a system clock edge
   always @(posedge i_clk) begin
      if (cnt == HALF_CYC - 1) begin
         cnt <= 0;
         o_osc <= ~o_osc;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

// ### cgu_tb.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk_sys = 0, i_nrst = 0, i_wake = 0, osc, erf;
   logic [1:0] i_mode_strap = 2'h0;
   logic i_psel = 0, i_penable = 0, i_pwrite = 0;
   logic [7:0] i_paddr = 8'h00, o_mod_en;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rdat;
   logic o_pready, o_pslverr, o_clk_cpu, o_clk_sys, o_locked;
   int mismatches = 0, cmp_count = 0, h, k;

   always #20 i_clk_sys = ~i_clk_sys;

   cgu_osc_model u_osc (.i_clk(i_clk_sys), .o_osc(osc));
   cgu_top uut (.i_clk_sys, .i_nrst, .i_osc(osc), .i_mode_strap,
      .i_wake, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .o_prdata, .o_pready, .o_pslverr, .o_clk_cpu, .o_clk_sys,
      .o_mod_en, .o_locked);

   task automatic finish_test;
      $display("TB: checks %0d errors %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge i_clk_sys);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk_sys);
      i_penable <= 1'b1;
      do @(posedge i_clk_sys);
      while (o_pready !== 1'b1);
      rdat = o_prdata;
      erf = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask

   // Poll status until the switch sequencer is idle
   task automatic idle;
      do apb(1'b0, 8'h08, 32'h0);
      while (rdat[2] !== 1'b0);
   endtask

   task automatic go(input logic [1:0] m);
      apb(1'b1, 8'h00, {29'h0, 1'b1, m});
      idle;
   endtask

   // Cycles over np cpu clock periods, each expected e cycles
   task automatic per(input int np, input int e, input int tol);
      int c, r, d, g;
      logic p;
      c = 0;
      r = -1;
      g = 0;
      p = 1'b1;
      while (r < np && g++ < 4000) begin
         @(posedge i_clk_sys);
         if (o_clk_cpu === 1'b1 && p !== 1'b1)
            r++;
         p = o_clk_cpu;
         if (r >= 0)
            c++;
      end
      d = c - 1;
      if (d >= np * e - tol && d <= np * e + tol)
         d = np * e;
      chk(d, np * e);
   endtask

   task automatic gaps;
      h = 0;
      k = 0;
      repeat (40) begin
         @(posedge i_clk_sys);
         h += (o_clk_cpu !== 1'b0);
         k += (o_clk_sys === 1'b1);
      end
   endtask

   initial begin
      repeat (16) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      idle;
      rd(8'h04, 32'h0);
      rd(8'h0C, 32'hFF);
      rd(8'h10, 32'h0);
      apb(1'b1, 8'h08, 32'h3F);
      rd(8'h08, 32'h8);
      rd(8'h14, 32'h0);
      chk(erf, 1'b1);
      per(4, 8, 1);
      $display("TB: reset and direct done");
      apb(1'b1, 8'h04, 32'h1001);
      per(4, 8, 1);
      go(2'h1);
      rd(8'h00, 32'h1);
      rd(8'h08, 32'h9);
      per(4, 32, 1);
      $display("TB: prescaler done");
      apb(1'b1, 8'h04, 32'h1030);
      go(2'h2);
      rd(8'h08, 32'hA);
      chk(o_locked, 1'b1);
      per(8, 4, 2);
      go(2'h3);
      rd(8'h08, 32'hB);
      per(4, 16, 1);
      go(2'h0);
      rd(8'h08, 32'h8);
      per(4, 8, 1);
      $display("TB: mode switching done");
      apb(1'b1, 8'h10, 32'h0F);
      apb(1'b1, 8'h00, 32'h08);
      repeat (30) @(posedge i_clk_sys);
      chk(o_mod_en, 8'h0F);
      rd(8'h08, 32'h18);
      gaps;
      chk(h, 0);
      chk(k != 0, 1'b1);
      i_wake <= 1'b1;
      @(posedge i_clk_sys);
      i_wake <= 1'b0;
      rd(8'h08, 32'h8);
      // Enables only change while the system clock is low
      repeat (8) @(posedge i_clk_sys);
      chk(o_mod_en, 8'hFF);
      apb(1'b1, 8'h00, 32'h10);
      // Let a running high phase finish before counting
      repeat (8) @(posedge i_clk_sys);
      gaps;
      chk(o_mod_en, 8'h00);
      chk(h + k, 0);
      rd(8'h08, 32'h28);
      apb(1'b1, 8'h00, 32'h0);
      repeat (30) @(posedge i_clk_sys);
      chk(o_mod_en, 8'hFF);
      $display("TB: sleep and power-down done");
      // Second reset with the straps asking for prescaler mode
      i_mode_strap <= 2'h1;
      i_nrst <= 1'b0;
      repeat (16) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      idle;
      rd(8'h08, 32'h9);
      rd(8'h04, 32'h0);
      per(4, 8, 1);
      $display("TB: strap and second reset done");
      finish_test;
   end

   initial begin
      repeat (40000) @(posedge i_clk_sys);
      mismatches++;
      finish_test;
   end
endmodule

bind cgu_top cgu_props u_props (.i_clk_sys, .i_nrst, .i_psel, .i_penable,
   .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
   .o_clk_cpu, .o_clk_sys, .o_mod_en);
